// ### inc/iap_pkg.sv
// constants and types for the independent axis profiler
package iap_pkg;

	// ---------------------------------------------------------------
	// geometry and bus map
	// ---------------------------------------------------------------
	localparam int NAXES = 4;
	localparam logic [22:0] MAP_HIGH_ZERO = 23'h000000; // haddr[31:9] must be zero
	localparam logic [5:0] OFS_ABS_TARGET = 6'h00; // absolute_target / destination_readback
	localparam logic [5:0] OFS_REL_DIST = 6'h04; // relative_distance / distance_readback
	localparam logic [5:0] OFS_SLEW = 6'h08; // slew_velocity / velocity_readback
	localparam logic [5:0] OFS_RAMP_UP = 6'h0C; // ramp_up_rate / ramp_up_readback
	localparam logic [5:0] OFS_RAMP_DOWN = 6'h10; // ramp_down_rate / ramp_down_readback
	localparam logic [5:0] OFS_JOG = 6'h14; // jog_velocity, signed
	localparam logic [5:0] OFS_SMOOTH = 6'h18; // smoothing_time_constant, shift 0..7
	localparam logic [5:0] OFS_INCREMENT = 6'h1C; // increment_target, write only
	localparam logic [5:0] OFS_CMD_POS = 6'h20; // commanded position, read only
	localparam logic [5:0] OFS_COMMAND = 6'h00; // global: begin_motion / halt_motion
	localparam logic [5:0] OFS_MODE = 6'h04; // global: jog select per axis
	localparam logic [5:0] OFS_STATUS = 6'h08; // global: profile_done_wait, in_position_wait

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int CMD_BEGIN_BIT = 8;
	localparam int CMD_HALT_BIT = 9;
	localparam int STAT_INPOS_LSB = 4;
	localparam logic [31:0] IN_POS_WINDOW = 32'h0000000A; // counts of tolerance
	localparam logic [31:0] RST_ZERO = 32'h00000000;
	localparam logic [2:0] RST_SMOOTH = 3'h0;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		AX_IDLE = 4'b0001,
		AX_MOVE = 4'b0010,
		AX_JOG = 4'b0100,
		AX_HALT = 4'b1000
	} iap_mode_t;

	typedef struct packed {
		iap_mode_t mode;
		logic [31:0] absoluteTarget;
		logic [31:0] relativeDistance;
		logic [31:0] slewVelocity;
		logic [31:0] rampUpRate;
		logic [31:0] rampDownRate;
		logic [31:0] jogVelocity;
		logic [2:0] smoothing;
		logic useRelative;
		logic [31:0] dest;
		logic [31:0] rawPos;
		logic [31:0] cmdPos;
		logic [31:0] vel;
	} iap_axis_t;

	typedef logic [NAXES-1:0][31:0] iap_pos_vec_t;

endpackage

// ### rtl/iap_profiler.sv
// independent axis trajectory profiler with an ahb-lite register slave
//
// How it works
// [RULE1] begin builds trapezoid or triangle profile
// [RULE2] positioning updates command every two samples
// [RULE3] done at last command; next accepted
// [RULE4] begin acts on selected axes; none=all
// [RULE5] slew and ramp-up change while moving
// [RULE6] ramp-down and targets frozen while moving
// [RULE7] halt ramps axis down anytime
// [RULE8] same-direction increment extends running target
// [RULE9] idle increment equals relative plus begin
// [RULE10] reachable speed: accelerate, cruise, decelerate exactly
// [RULE11] short move: early deceleration, triangular profile
// [RULE12] jog direction from jog velocity sign
// [RULE13] jog ramps up, holds until change/halt
// [RULE14] jog speed change ramps, never steps
// [RULE15] jog increment shifts position instantly
// [RULE16] jog emits position every other sample
// [RULE17] target readback: destination moving, else command
// [RULE18] rates, speed, distance read back per axis
// [RULE19] per-axis smoothing shapes command output
// [RULE20] profile-done and in-position wait flags
// [RULE21] each axis parameter written independently
// [RULE22] idle axis holds last command position; smoothing still moves the command after done
// [RULE23] halt uses ramp-down; done at zero velocity
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module iap_profiler (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// servo side
	input wire logic sampleTick,
	input wire iap_pkg::iap_pos_vec_t actualPos,
	output iap_pkg::iap_pos_vec_t commandPos,
	output logic [iap_pkg::NAXES-1:0] profileDone,
	output logic [iap_pkg::NAXES-1:0] inPosition
);
	import iap_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		iap_axis_t [NAXES-1:0] ax; // per-axis profile state
		logic [NAXES-1:0] jogSelect; // 1: axis runs in jog mode
		logic [NAXES-1:0] inPos; // registered in-position flags
		logic stepPhase; // alternates on each sample tick
		logic dActive; // data phase pending
		logic dWrite; // pending phase is a write
		logic [8:0] dAddr; // pending word address
		logic [31:0] rdata; // read data for the data phase
	} iap_state_t;

	iap_state_t s_q; // registered state
	iap_state_t s_d; // next state

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// magnitude of a two's complement word
	function automatic logic [31:0] magOf(input logic [31:0] v);
		magOf = v[31] ? (~v + 32'h00000001) : v;
	endfunction

	// one ramp step of a signed velocity toward a signed goal
	function automatic logic [31:0] rampTo(input logic [31:0] v, input logic [31:0] goal,
		input logic [31:0] up, input logic [31:0] down);
		logic inc;
		logic [31:0] rate;
		logic signed [33:0] sv;
		logic signed [33:0] sg;
		logic signed [33:0] r;
		inc = (v == RST_ZERO) || ((v[31] == goal[31]) && (magOf(goal) > magOf(v)));
		// growing speed uses ramp-up, shrinking speed uses ramp-down
		rate = inc ? up : down;
		sv = {{2{v[31]}}, v};
		sg = {{2{goal[31]}}, goal};
		r = {2'b00, rate};
		if (sv < sg) begin
			sv = sv + r;
			if (sv > sg) begin
				sv = sg;
			end
		end else begin
			sv = sv - r;
			if (sv < sg) begin
				sv = sg;
			end
		end
		rampTo = sv[31:0];
	endfunction

	// one profile step of an axis, run every second sample tick
	function automatic iap_axis_t stepAxis(input iap_axis_t a);
		iap_axis_t n;
		logic [31:0] diff;
		logic neg;
		logic [31:0] rem;
		logic [31:0] m;
		logic [31:0] vn;
		logic [63:0] vSq;
		logic [63:0] brake;
		logic [31:0] err;
		logic [31:0] sh;
		n = a;
		diff = a.dest - a.rawPos;
		neg = diff[31];
		rem = magOf(diff);
		m = magOf(a.vel);
		vSq = 64'(m) * 64'(m);
		brake = 64'(a.rampDownRate) * 64'({rem, 1'b0});
		vn = m;
		unique case (a.mode)
			AX_MOVE: begin
				// [RULE11] brake early once stopping distance covers remainder
				if (vSq >= brake) begin
					vn = (m > a.rampDownRate) ? (m - a.rampDownRate) : 32'h00000001;
				// [RULE10] accelerate toward slew speed
				end else if (m < a.slewVelocity) begin
					vn = ((a.slewVelocity - m) > a.rampUpRate) ? (m + a.rampUpRate) : a.slewVelocity;
				// [RULE5] lowered slew on the fly is reached by ramping down
				end else if (m > a.slewVelocity) begin
					vn = ((m - a.slewVelocity) > a.rampDownRate) ? (m - a.rampDownRate) :
						a.slewVelocity;
				end
				// [RULE10] last step clipped so the end lands exactly on dest
				if (vn >= rem) begin
					n.rawPos = a.dest;
					n.vel = RST_ZERO;
					// [RULE3] profile complete at its final command
					n.mode = AX_IDLE;
				end else begin
					n.rawPos = neg ? (a.rawPos - vn) : (a.rawPos + vn);
					n.vel = neg ? (~vn + 32'h00000001) : vn;
				end
			end
			AX_JOG: begin
				// [RULE12] sign of jog velocity sets direction
				// [RULE14] speed changes are ramped
				n.vel = rampTo(a.vel, a.jogVelocity, a.rampUpRate, a.rampDownRate);
				// [RULE16] velocity integrated into a position trajectory
				n.rawPos = a.rawPos + n.vel;
			end
			AX_HALT: begin
				// [RULE23] halt ramps at ramp-down rate to zero velocity
				n.vel = rampTo(a.vel, RST_ZERO, a.rampDownRate, a.rampDownRate);
				n.rawPos = a.rawPos + n.vel;
				if (n.vel == RST_ZERO) begin
					n.mode = AX_IDLE;
					n.dest = n.rawPos;
				end
			end
			AX_IDLE: begin
				// [RULE22] idle axis keeps its last position
				n.vel = RST_ZERO;
			end
		endcase
		// [RULE19] first-order smoothing, time constant as a shift
		err = n.rawPos - a.cmdPos;
		sh = 32'($signed(err) >>> a.smoothing);
		if ((sh == RST_ZERO) && (err != RST_ZERO)) begin
			sh = err[31] ? 32'hFFFFFFFF : 32'h00000001;
		end
		n.cmdPos = a.cmdPos + sh;
		return n;
	endfunction

	// register read mux, word address in
	function automatic logic [31:0] regRead(input iap_state_t st, input logic [8:0] wa);
		iap_axis_t a;
		logic [31:0] stat;
		a = st.ax[wa[5:4]];
		regRead = RST_ZERO;
		stat = RST_ZERO;
		for (int i = 0; i < NAXES; i++) begin
			stat[i] = (st.ax[i].mode == AX_IDLE);
			stat[STAT_INPOS_LSB + i] = st.inPos[i];
		end
		if (wa[6]) begin
			if ({wa[3:0], 2'b00} == OFS_MODE) begin
				regRead = {28'h0000000, st.jogSelect};
			end else if ({wa[3:0], 2'b00} == OFS_STATUS) begin
				// [RULE20] both wait conditions visible per axis
				regRead = stat;
			end
		end else begin
			unique case ({wa[3:0], 2'b00})
				// [RULE17] destination while moving, else commanded position
				OFS_ABS_TARGET: regRead = (a.mode != AX_IDLE) ? a.dest : a.cmdPos;
				// [RULE18] stored values read back
				OFS_REL_DIST: regRead = a.relativeDistance;
				OFS_SLEW: regRead = a.slewVelocity;
				OFS_RAMP_UP: regRead = a.rampUpRate;
				OFS_RAMP_DOWN: regRead = a.rampDownRate;
				OFS_JOG: regRead = a.jogVelocity;
				OFS_SMOOTH: regRead = {29'h00000000, a.smoothing};
				OFS_CMD_POS: regRead = a.cmdPos;
				default: regRead = RST_ZERO;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	// one pass: profile step, bus write, then address phase capture
	always_comb begin
		logic [1:0] axSel;
		logic [5:0] ofs;
		logic [NAXES-1:0] mask;
		logic [31:0] diff;
		s_d = s_q;
		axSel = s_q.dAddr[5:4];
		ofs = {s_q.dAddr[3:0], 2'b00};
		mask = hwdata[NAXES-1:0];
		diff = RST_ZERO;
		// [RULE2] a profile step on every second sample tick
		if (sampleTick) begin
			s_d.stepPhase = ~s_q.stepPhase;
			if (s_q.stepPhase) begin
				for (int i = 0; i < NAXES; i++) begin
					s_d.ax[i] = stepAxis(s_q.ax[i]);
				end
			end
		end
		// data phase of a write: ahb data arrives one cycle after address
		if (s_q.dActive && s_q.dWrite) begin
			if (s_q.dAddr[6]) begin
				if (ofs == OFS_COMMAND) begin
					// [RULE4] empty axis mask selects every axis
					if (mask == '0) begin
						mask = '1;
					end
					for (int i = 0; i < NAXES; i++) begin
						// [RULE7] halt honoured in any moving state
						if (mask[i] && hwdata[CMD_HALT_BIT] && (s_d.ax[i].mode != AX_IDLE)) begin
							s_d.ax[i].mode = AX_HALT;
						// [RULE3] begin only taken once the axis is idle
						end else if (mask[i] && hwdata[CMD_BEGIN_BIT] &&
							(s_d.ax[i].mode == AX_IDLE)) begin
							// [RULE13] jog begins by ramping toward jog velocity
							if (s_q.jogSelect[i]) begin
								s_d.ax[i].mode = AX_JOG;
							// [RULE1] begin launches a positioning profile
							end else begin
								s_d.ax[i].mode = AX_MOVE;
								s_d.ax[i].dest = s_q.ax[i].useRelative ?
									(s_d.ax[i].rawPos + s_q.ax[i].relativeDistance) :
									s_q.ax[i].absoluteTarget;
							end
						end
					end
				end else if (ofs == OFS_MODE) begin
					s_d.jogSelect = hwdata[NAXES-1:0];
				end
			end else begin
				// [RULE21] writes touch one axis only
				unique case (ofs)
					OFS_ABS_TARGET: begin
						// [RULE6] target frozen until the profile ends
						if (s_d.ax[axSel].mode == AX_IDLE) begin
							s_d.ax[axSel].absoluteTarget = hwdata;
							s_d.ax[axSel].useRelative = 1'b0;
						end
					end
					OFS_REL_DIST: begin
						// [RULE6] distance frozen until the profile ends
						if (s_d.ax[axSel].mode == AX_IDLE) begin
							s_d.ax[axSel].relativeDistance = hwdata;
							s_d.ax[axSel].useRelative = 1'b1;
						end
					end
					// [RULE5] speed and ramp-up take effect at once
					OFS_SLEW: s_d.ax[axSel].slewVelocity = hwdata;
					OFS_RAMP_UP: s_d.ax[axSel].rampUpRate = hwdata;
					OFS_RAMP_DOWN: begin
						// [RULE6] ramp-down frozen until the profile ends
						if (s_d.ax[axSel].mode == AX_IDLE) begin
							s_d.ax[axSel].rampDownRate = hwdata;
						end
					end
					// [RULE13] new jog velocity followed by the ramp
					OFS_JOG: s_d.ax[axSel].jogVelocity = hwdata;
					OFS_SMOOTH: s_d.ax[axSel].smoothing = hwdata[2:0];
					OFS_INCREMENT: begin
						diff = s_d.ax[axSel].dest - s_d.ax[axSel].rawPos;
						unique case (s_d.ax[axSel].mode)
							AX_MOVE: begin
								// [RULE8] only same direction extends the target
								if (diff[31] == hwdata[31]) begin
									s_d.ax[axSel].dest = s_d.ax[axSel].dest + hwdata;
								end
							end
							AX_JOG: begin
								// [RULE15] jog position jumps by the increment
								s_d.ax[axSel].rawPos = s_d.ax[axSel].rawPos + hwdata;
							end
							AX_IDLE: begin
								// [RULE9] idle increment is relative move plus begin
								s_d.ax[axSel].relativeDistance = hwdata;
								s_d.ax[axSel].useRelative = 1'b1;
								if (s_q.jogSelect[axSel]) begin
									s_d.ax[axSel].rawPos = s_d.ax[axSel].rawPos + hwdata;
								end else begin
									s_d.ax[axSel].mode = AX_MOVE;
									s_d.ax[axSel].dest = s_d.ax[axSel].rawPos + hwdata;
								end
							end
							AX_HALT: begin
								// stopping axis ignores increments
								s_d.ax[axSel].dest = s_d.ax[axSel].dest;
							end
						endcase
					end
					default: begin
						// read-only or unmapped: write dropped
						s_d.jogSelect = s_d.jogSelect;
					end
				endcase
			end
		end
		// [RULE20] in position: profile done, smoothing settled, motor near
		for (int i = 0; i < NAXES; i++) begin
			diff = actualPos[i] - s_d.ax[i].rawPos;
			s_d.inPos[i] = (s_d.ax[i].mode == AX_IDLE) &&
				(s_d.ax[i].cmdPos == s_d.ax[i].rawPos) && (magOf(diff) <= IN_POS_WINDOW);
		end
		// address phase capture; read data taken from the updated state
		s_d.dActive = 1'b0;
		if (hsel && htrans[1] && hready) begin
			s_d.dActive = 1'b1;
			s_d.dWrite = hwrite;
			s_d.dAddr = (haddr[31:9] == MAP_HIGH_ZERO) ? haddr[10:2] : 9'h0FF;
			if (!hwrite) begin
				// unmapped addresses fall to a hole that reads zero
				s_d.rdata = (haddr[31:9] == MAP_HIGH_ZERO) ? regRead(s_d, haddr[10:2]) : RST_ZERO;
			end
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// asynchronous reset to constants only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NAXES; i++) begin
				s_q.ax[i].mode <= AX_IDLE;
				s_q.ax[i].absoluteTarget <= RST_ZERO;
				s_q.ax[i].relativeDistance <= RST_ZERO;
				s_q.ax[i].slewVelocity <= RST_ZERO;
				s_q.ax[i].rampUpRate <= RST_ZERO;
				s_q.ax[i].rampDownRate <= RST_ZERO;
				s_q.ax[i].jogVelocity <= RST_ZERO;
				s_q.ax[i].smoothing <= RST_SMOOTH;
				s_q.ax[i].useRelative <= 1'b0;
				s_q.ax[i].dest <= RST_ZERO;
				s_q.ax[i].rawPos <= RST_ZERO;
				s_q.ax[i].cmdPos <= RST_ZERO;
				s_q.ax[i].vel <= RST_ZERO;
			end
			s_q.jogSelect <= '0;
			s_q.inPos <= '0;
			s_q.stepPhase <= 1'b0;
			s_q.dActive <= 1'b0;
			s_q.dWrite <= 1'b0;
			s_q.dAddr <= 9'h000;
			s_q.rdata <= RST_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// zero-wait slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;

	// per-axis command and status: command and in-position from flip-flops, done decoded from the mode flip-flops
	always_comb begin
		for (int i = 0; i < NAXES; i++) begin
			// [RULE22] idle command position holds once smoothing has reached the raw position
			commandPos[i] = s_q.ax[i].cmdPos;
			profileDone[i] = (s_q.ax[i].mode == AX_IDLE);
		end
		inPosition = s_q.inPos;
	end

endmodule

`default_nettype wire

// ### test/iap_profiler_checker.sv
// concurrent checks on the profiler ports
`timescale 1ns/1ps
`default_nettype none
module iap_profiler_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	// servo side
	input wire logic sampleTick,
	input wire iap_pkg::iap_pos_vec_t actualPos,
	input wire iap_pkg::iap_pos_vec_t commandPos,
	input wire logic [iap_pkg::NAXES-1:0] profileDone,
	input wire logic [iap_pkg::NAXES-1:0] inPosition
);
	import iap_pkg::*;
	logic wrData_q; // any write in data phase
	logic cmdData_q; // command write in data phase
	// --------------------------------
	// data phase markers
	// --------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrData_q <= 1'b0;
			cmdData_q <= 1'b0;
		end else begin
			wrData_q <= hsel && htrans[1] && hready && hwrite;
			cmdData_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'h00000100;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// --------------------------------
	// assertions
	// --------------------------------
	a_cmd_on_tick: assert property ($changed(commandPos) |-> $past(sampleTick))
		else $error("command position moved off a sample tick");
	a_step_spacing: assert property ($changed(commandPos) |=> $stable(commandPos)[*7])
		else $error("command position steps closer than two ticks");
	a_done_on_step: assert property (
		(profileDone & ~$past(profileDone)) != 4'h0 |-> $past(sampleTick))
		else $error("profile done rose off a step");
	a_done_by_write: assert property (
		(~profileDone & $past(profileDone)) != 4'h0 |-> $past(wrData_q))
		else $error("idle axis started without a write");
	a_inpos_after_start: assert property ($fell(profileDone[0]) |=> !inPosition[0])
		else $error("in position while axis moves");
	a_inpos_when_idle: assert property (
		(inPosition & ~profileDone & ~$past(profileDone)) == 4'h0)
		else $error("in position without profile done");
	// the flag is judged against the settled command, which equals the raw position
	a_inpos_window: assert property ($rose(inPosition[0]) |->
		($signed($past(actualPos[0]) - commandPos[0]) <= 10) &&
		($signed($past(actualPos[0]) - commandPos[0]) >= -10))
		else $error("in position outside the window");
	a_halt_bounded: assert property (
		cmdData_q && hwdata[CMD_HALT_BIT] && hwdata[3:0] == 4'h0 |-> ##[1:400] (&profileDone))
		else $error("halt did not finish in time");
	// main scenarios reached
	c_move_done: cover property ($rose(profileDone[0]));
	c_halt: cover property (cmdData_q && hwdata[CMD_HALT_BIT]);
	c_settled: cover property ($rose(inPosition[0]));
endmodule
bind iap_profiler iap_profiler_checker u_chk (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .sampleTick(sampleTick),
	.actualPos(actualPos), .commandPos(commandPos), .profileDone(profileDone),
	.inPosition(inPosition));
`default_nettype wire

// ### test/iap_servo_model.sv
// servo loop stand-in: sample ticks and motor positions
`timescale 1ns/1ps
`default_nettype none
module iap_servo_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// lagging motor when high
	input wire logic slow,
	// profiler side
	input wire iap_pkg::iap_pos_vec_t commandPos,
	output logic sampleTick,
	output iap_pkg::iap_pos_vec_t actualPos
);
	import iap_pkg::*;
	logic [1:0] div_q; // tick every fourth clock
	// motor halves its error per tick when slow, so it settles late
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= 2'h0;
			sampleTick <= 1'b0;
			actualPos <= '0;
		end else begin
			div_q <= div_q + 2'h1;
			sampleTick <= div_q == 2'h3;
			for (int i = 0; i < NAXES; i++) begin
				if (sampleTick) begin
					actualPos[i] <= slow ? actualPos[i] + 32'($signed(commandPos[i] - actualPos[i]) >>> 1)
						: commandPos[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### test/independent_axis_profiler_tb.sv
// bus-driven tests of the axis profiler
`timescale 1ns/1ps
`default_nettype none
module independent_axis_profiler_tb;
	import iap_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic slow = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, sampleTick;
	logic [31:0] hrdata, p;
	iap_pos_vec_t actualPos, commandPos;
	logic [NAXES-1:0] profileDone, inPosition;
	int badCount = 0;
	int checks = 0;
	int tickN, v0, v1, pv1, pk0, pk1, mn1, acc1;
	logic stepSeen;
	logic [31:0] prev0, prev1;
	assign hready = hreadyout;
	always #2.5 clk = ~clk;
	iap_profiler u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sampleTick(sampleTick), .actualPos(actualPos),
		.commandPos(commandPos), .profileDone(profileDone), .inPosition(inPosition));
	iap_servo_model u_servo (.clk(clk), .rstn(rstn), .slow(slow), .commandPos(commandPos),
		.sampleTick(sampleTick), .actualPos(actualPos));
	// per-step velocity of axes 0 and 1; steps fall on every second tick
	always @(posedge clk) begin
		if (!rstn) begin
			tickN = 0;
			stepSeen = 1'b0;
		end else begin
			if (stepSeen) begin
				v0 = int'($signed(commandPos[0] - prev0));
				v1 = int'($signed(commandPos[1] - prev1));
				if (v0 > pk0) pk0 = v0;
				if (v1 > pk1) pk1 = v1;
				if (v1 < mn1) mn1 = v1;
				if ((v1 - pv1) > acc1 || (pv1 - v1) > acc1) acc1 = (v1 > pv1) ? v1 - pv1 : pv1 - v1;
				pv1 = v1;
			end
			prev0 = commandPos[0];
			prev1 = commandPos[1];
			stepSeen = sampleTick && tickN[0];
			if (sampleTick) tickN++;
		end
	end
	function automatic logic [31:0] ad(input int n, input logic [5:0] o);
		return 32'(n * 64) + {26'h0, o};
	endfunction
	function automatic logic [31:0] gad(input logic [5:0] o);
		return 32'h00000100 + {26'h0, o};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic ok(input string nm, input logic c);
		chk(nm, {31'h0, c}, 32'h1);
	endtask
	// wait for the slave to be ready; only the watchdog ends a hung wait
	task automatic rdy();
		do begin
			@(posedge clk);
		end while (hready !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(nm, r, exp);
	endtask
	task automatic cfg(input int n, input logic [31:0] rel, sl, up, dn);
		wr(ad(n, OFS_REL_DIST), rel);
		wr(ad(n, OFS_SLEW), sl);
		wr(ad(n, OFS_RAMP_UP), up);
		wr(ad(n, OFS_RAMP_DOWN), dn);
	endtask
	task automatic cmd(input int bitNo, input logic [3:0] m);
		wr(gad(OFS_COMMAND), (32'h1 << bitNo) | {28'h0, m});
	endtask
	task automatic waitDone(input logic [3:0] m);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((profileDone & m) !== m && n < 3000);
		chk("profile done", {28'h0, profileDone & m}, {28'h0, m});
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#100000;
		badCount++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc("status", gad(OFS_STATUS), 32'h000000FF);
		rdc("slew reset", ad(1, OFS_SLEW), RST_ZERO);
		rdc("smooth reset", ad(2, OFS_SMOOTH), {29'h0, RST_SMOOTH});
		for (int n = 0; n < 4; n++) begin
			cfg(n, 32'h11 * n + 1, 32'h11 * n + 2, 32'h11 * n + 3, 32'h11 * n + 4);
		end
		wr(32'h00000200, 32'hFFFFFFFF);
		rdc("unmapped", 32'h00000200, 32'h0);
		for (int n = 0; n < 4; n++) begin
			rdc("distance", ad(n, OFS_REL_DIST), 32'h11 * n + 1);
			rdc("speed", ad(n, OFS_SLEW), 32'h11 * n + 2);
			rdc("ramp up", ad(n, OFS_RAMP_UP), 32'h11 * n + 3);
			rdc("ramp down", ad(n, OFS_RAMP_DOWN), 32'h11 * n + 4);
		end
		chk("okay response", {31'h0, hresp}, 32'h0);
		$display("test registers finished");
		cfg(0, 32'd400, 32'd10, 32'd2, 32'd2);
		cfg(1, 32'd20, 32'd10, 32'd2, 32'd2);
		pk0 = 0;
		pk1 = 0;
		cmd(CMD_BEGIN_BIT, 4'h3);
		wr(ad(0, OFS_SLEW), 32'd12);
		wr(ad(0, OFS_RAMP_DOWN), 32'd7);
		wr(ad(0, OFS_ABS_TARGET), 32'd5);
		rdc("destination", ad(0, OFS_ABS_TARGET), 32'd400);
		waitDone(4'h3);
		chk("trapezoid end", commandPos[0], 32'd400);
		chk("triangle end", commandPos[1], 32'd20);
		chk("unselected axis", commandPos[2], 32'd0);
		chk("new slew peak", 32'(pk0), 32'd12);
		ok("triangle peak", pk1 < 10 && pk1 > 0);
		rdc("frozen ramp down", ad(0, OFS_RAMP_DOWN), 32'd2);
		$display("test profiles finished");
		cfg(2, 32'd1000, 32'd10, 32'd2, 32'd2);
		cmd(CMD_BEGIN_BIT, 4'h4);
		repeat (150) @(posedge clk);
		cmd(CMD_HALT_BIT, 4'h0);
		waitDone(4'hF);
		ok("halted early", commandPos[2] < 32'd1000 && commandPos[2] > 32'd100);
		$display("test halt finished");
		cfg(3, 32'd100, 32'd4, 32'd1, 32'd1);
		cmd(CMD_BEGIN_BIT, 4'h8);
		wr(ad(3, OFS_INCREMENT), 32'd50);
		wr(ad(3, OFS_INCREMENT), -32'sd20);
		waitDone(4'h8);
		chk("extended target", commandPos[3], 32'd150);
		wr(ad(3, OFS_INCREMENT), 32'd30);
		waitDone(4'h8);
		chk("idle increment", commandPos[3], 32'd180);
		rdc("idle target", ad(3, OFS_ABS_TARGET), 32'd180);
		$display("test increment finished");
		wr(gad(OFS_MODE), 32'h2);
		rdc("mode", gad(OFS_MODE), 32'h2);
		wr(ad(1, OFS_JOG), -32'sd8);
		pk1 = 0;
		mn1 = 0;
		acc1 = 0;
		pv1 = 0;
		p = commandPos[1];
		cmd(CMD_BEGIN_BIT, 4'h2);
		repeat (200) @(posedge clk);
		ok("reverse jog", $signed(commandPos[1]) < $signed(p));
		chk("jog speed", 32'(mn1), -32'sd8);
		wr(ad(1, OFS_JOG), 32'd4);
		repeat (200) @(posedge clk);
		chk("new jog speed", 32'(pk1), 32'd4);
		cmd(CMD_HALT_BIT, 4'h2);
		waitDone(4'h2);
		ok("ramped change", acc1 <= 2 && acc1 > 0);
		p = commandPos[1];
		wr(ad(1, OFS_INCREMENT), 32'd77);
		repeat (40) @(posedge clk);
		chk("jog increment", commandPos[1], p + 32'd77);
		$display("test jog finished");
		slow <= 1'b1;
		wr(ad(0, OFS_SMOOTH), 32'h3);
		rdc("smoothing", ad(0, OFS_SMOOTH), 32'h3);
		wr(ad(0, OFS_REL_DIST), 32'd50);
		cmd(CMD_BEGIN_BIT, 4'h1);
		waitDone(4'h1);
		chk("lagging at done", {31'h0, inPosition[0]}, 32'h0);
		repeat (800) @(posedge clk);
		chk("smoothed end", commandPos[0], 32'd450);
		rdc("status settled", gad(OFS_STATUS), 32'h000000FF);
		$display("test smoothing finished");
		complete_run();
	end
endmodule
`default_nettype wire
